// [core/ifb_pkg.sv]
// Package: register map, bit positions and masks of the interrupt flag bank
package ifb_pkg;
   // Register byte offsets on APB
   localparam logic [11:0] IFB_OFF_FLAGS0  = 12'h000;
   localparam logic [11:0] IFB_OFF_FLAGS1  = 12'h004;
   localparam logic [11:0] IFB_OFF_IRQSTAT = 12'h008;
   localparam logic [11:0] IFB_OFF_IRQCLR  = 12'h00c;
   localparam logic [11:0] IFB_OFF_IRQEN   = 12'h010;
   localparam int          IFB_ADDR_W      = 12;
   // Implemented-bit masks of the two flag registers
   localparam logic [15:0] IFB_MASK0       = 16'h3fef;
   localparam logic [15:0] IFB_MASK1       = 16'hfedf;
   // Reset values
   localparam logic [15:0] IFB_RST_FLAGS   = 16'h0000;
   localparam logic [1:0]  IFB_RST_IRQ     = 2'h0;
   // Bit positions, bank 0
   localparam int IFB_B0_ADC = 13, IFB_B0_S1TX = 12, IFB_B0_S1RX = 11, IFB_B0_SPIEV = 10;
   localparam int IFB_B0_SPIFLT = 9, IFB_B0_TMR3 = 8, IFB_B0_TMR2 = 7, IFB_B0_CMP2 = 6;
   localparam int IFB_B0_CAP2 = 5, IFB_B0_TMR1 = 3, IFB_B0_CMP1 = 2, IFB_B0_CAP1 = 1, IFB_B0_EXT0 = 0;
   // Bit positions, bank 1
   localparam int IFB_B1_S2TX = 15, IFB_B1_S2RX = 14, IFB_B1_EXT2 = 13, IFB_B1_TMR5 = 12;
   localparam int IFB_B1_TMR4 = 11, IFB_B1_CMP4 = 10, IFB_B1_CMP3 = 9, IFB_B1_CAP8 = 7;
   localparam int IFB_B1_CAP7 = 6, IFB_B1_EXT1 = 4, IFB_B1_CHG = 3, IFB_B1_CMPR = 2;
   localparam int IFB_B1_I2CM = 1, IFB_B1_I2CS = 0;
   // Summary interrupt status bits (one per bank)
   localparam int IFB_IRQ_BANK0 = 0, IFB_IRQ_BANK1 = 1;
endpackage : ifb_pkg

// [core/ifb_flag_bank.sv]
// Module: latched interrupt request flag bank with APB slave
`timescale 1ns/1ps
module ifb_flag_bank (
   // Clock, enable, reset
   input  wire logic                        mclk,
   input  wire logic                        clkEn,
   input  wire logic                        rst,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [ifb_pkg::IFB_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Event pulses, bank 0
   input  wire logic                        adcDone,
   input  wire logic                        serial1Tx,
   input  wire logic                        serial1Rx,
   input  wire logic                        spiPort1Event,
   input  wire logic                        spiPort1Fault,
   input  wire logic                        timer3,
   input  wire logic                        timer2,
   input  wire logic                        compare2,
   input  wire logic                        capture2,
   input  wire logic                        timer1,
   input  wire logic                        compare1,
   input  wire logic                        capture1,
   input  wire logic                        extPin0,
   // Event pulses, bank 1
   input  wire logic                        serial2Tx,
   input  wire logic                        serial2Rx,
   input  wire logic                        extPin2,
   input  wire logic                        timer5,
   input  wire logic                        timer4,
   input  wire logic                        compare4,
   input  wire logic                        compare3,
   input  wire logic                        capture8,
   input  wire logic                        capture7,
   input  wire logic                        extPin1,
   input  wire logic                        changeNotify,
   input  wire logic                        comparator,
   input  wire logic                        i2cMaster1,
   input  wire logic                        i2cSlave1,
   // Flag state to CPU arbitration and interrupt
   output logic      [15:0]                 interruptFlagsBank0,
   output logic      [15:0]                 interruptFlagsBank1,
   output logic                             irq
);
   import ifb_pkg::*;

   // Flag registers and their next values
   logic [15:0] flags0_reg;
   logic [15:0] flags0_next;
   logic [15:0] flags1_reg;
   logic [15:0] flags1_next;

   // Per-bank summary status and its enables
   logic [1:0]  irqStat_reg;
   logic [1:0]  irqStat_next;
   logic [1:0]  irqEn_reg;
   logic [1:0]  irqEn_next;

   // Read data held for the access phase
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;

   // Event requests placed at their flag positions
   logic [15:0] evt0;
   logic [15:0] evt1;

   // Bus qualifiers
   logic        wrAcc;
   logic        rdAcc;
   logic        addrOk;

   // Register hits of the current transfer
   logic        hitFlags0;
   logic        hitFlags1;
   logic        hitStat;
   logic        hitClr;
   logic        hitEn;

   // Per-register write strobes of the access cycle
   logic        wrFlags0;
   logic        wrFlags1;
   logic        wrClr;
   logic        wrEn;

   // Merge a write into a 16-bit register honouring the two low byte strobes
   function automatic logic [15:0] strbMerge(input logic [15:0] oldV, input logic [31:0] wd,
                                             input logic [3:0] st);
      strbMerge = {st[1] ? wd[15:8] : oldV[15:8],
                   st[0] ? wd[7:0]  : oldV[7:0]};
   endfunction : strbMerge

   // Address match against one register offset
   function automatic logic regHit(input logic [IFB_ADDR_W-1:0] a, input logic [IFB_ADDR_W-1:0] off);
      regHit = (a == off);
   endfunction : regHit

   // Events are or-ed in last so a request in the cycle of a clearing write is never lost
   function automatic logic [15:0] latchEvents(input logic [15:0] cur, input logic [15:0] evt,
                                               input logic [15:0] mask);
      latchEvents = (cur | evt) & mask;
   endfunction : latchEvents

   // Any request of one bank, limited to implemented positions
   function automatic logic anyEvent(input logic [15:0] evt, input logic [15:0] mask);
      anyEvent = |(evt & mask);
   endfunction : anyEvent

   // Flag word as software reads it, unimplemented positions forced to zero
   function automatic logic [31:0] readFlags(input logic [15:0] flags, input logic [15:0] mask);
      readFlags = {16'h0000, flags & mask};
   endfunction : readFlags

   // Event vectors placed in vector order
   always_comb begin
      evt0 = 16'h0000;
      evt1 = 16'h0000;
      evt0[IFB_B0_ADC]    = adcDone;
      evt0[IFB_B0_S1TX]   = serial1Tx;
      evt0[IFB_B0_S1RX]   = serial1Rx;
      evt0[IFB_B0_SPIEV]  = spiPort1Event;
      evt0[IFB_B0_SPIFLT] = spiPort1Fault;
      evt0[IFB_B0_TMR3]   = timer3;
      evt0[IFB_B0_TMR2]   = timer2;
      evt0[IFB_B0_CMP2]   = compare2;
      evt0[IFB_B0_CAP2]   = capture2;
      evt0[IFB_B0_TMR1]   = timer1;
      evt0[IFB_B0_CMP1]   = compare1;
      evt0[IFB_B0_CAP1]   = capture1;
      evt0[IFB_B0_EXT0]   = extPin0;
      evt1[IFB_B1_S2TX]   = serial2Tx;
      evt1[IFB_B1_S2RX]   = serial2Rx;
      evt1[IFB_B1_EXT2]   = extPin2;
      evt1[IFB_B1_TMR5]   = timer5;
      evt1[IFB_B1_TMR4]   = timer4;
      evt1[IFB_B1_CMP4]   = compare4;
      evt1[IFB_B1_CMP3]   = compare3;
      evt1[IFB_B1_CAP8]   = capture8;
      evt1[IFB_B1_CAP7]   = capture7;
      evt1[IFB_B1_EXT1]   = extPin1;
      evt1[IFB_B1_CHG]    = changeNotify;
      evt1[IFB_B1_CMPR]   = comparator;
      evt1[IFB_B1_I2CM]   = i2cMaster1;
      evt1[IFB_B1_I2CS]   = i2cSlave1;
   end

   // Register decode of the addressed word
   assign hitFlags0 = regHit(paddr, IFB_OFF_FLAGS0);
   assign hitFlags1 = regHit(paddr, IFB_OFF_FLAGS1);
   assign hitStat   = regHit(paddr, IFB_OFF_IRQSTAT);
   assign hitClr    = regHit(paddr, IFB_OFF_IRQCLR);
   assign hitEn     = regHit(paddr, IFB_OFF_IRQEN);
   assign addrOk    = hitFlags0 | hitFlags1 | hitStat | hitClr | hitEn;

   // APB qualifiers: zero-wait slave, writes land in the access cycle, reads are captured in setup
   assign wrAcc   = psel & penable & pwrite;
   assign rdAcc   = psel & ~penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addrOk;

   // Write strobes; an unmapped address hits nothing, so its write is dropped
   assign wrFlags0 = wrAcc & hitFlags0;
   assign wrFlags1 = wrAcc & hitFlags1;
   assign wrClr    = wrAcc & hitClr & pstrb[0];
   assign wrEn     = wrAcc & hitEn & pstrb[0];

   // Bank 0 next value: software write first, then events on top
   always_comb begin
      flags0_next = flags0_reg;
      if (wrFlags0) begin
         flags0_next = strbMerge(flags0_reg, pwdata, pstrb);
      end
      flags0_next = latchEvents(flags0_next, evt0, IFB_MASK0);
   end

   // Bank 0 register, cleared by reset and frozen while clkEn is low
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags0_reg <= IFB_RST_FLAGS;
      end else if (clkEn) begin
         flags0_reg <= flags0_next;
      end
   end

   // Bank 1 next value: software write first, then events on top
   always_comb begin
      flags1_next = flags1_reg;
      if (wrFlags1) begin
         flags1_next = strbMerge(flags1_reg, pwdata, pstrb);
      end
      flags1_next = latchEvents(flags1_next, evt1, IFB_MASK1);
   end

   // Bank 1 register, cleared by reset and frozen while clkEn is low
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags1_reg <= IFB_RST_FLAGS;
      end else if (clkEn) begin
         flags1_reg <= flags1_next;
      end
   end

   // Summary status: the clear register drops bits, a bank event sets its bit
   always_comb begin
      irqStat_next = irqStat_reg;
      if (wrClr) begin
         irqStat_next = irqStat_reg & ~pwdata[1:0];
      end
      // Events applied after the clear so set wins
      irqStat_next[IFB_IRQ_BANK0] = irqStat_next[IFB_IRQ_BANK0] | anyEvent(evt0, IFB_MASK0);
      irqStat_next[IFB_IRQ_BANK1] = irqStat_next[IFB_IRQ_BANK1] | anyEvent(evt1, IFB_MASK1);
   end

   // Summary status register
   always_ff @(posedge mclk) begin
      if (rst) begin
         irqStat_reg <= IFB_RST_IRQ;
      end else if (clkEn) begin
         irqStat_reg <= irqStat_next;
      end
   end

   // Enable register: whole-field write through the low byte strobe
   always_comb begin
      irqEn_next = irqEn_reg;
      if (wrEn) begin
         irqEn_next = pwdata[1:0];
      end
   end

   // Enable register
   always_ff @(posedge mclk) begin
      if (rst) begin
         irqEn_reg <= IFB_RST_IRQ;
      end else if (clkEn) begin
         irqEn_reg <= irqEn_next;
      end
   end

   // Read data captured at the setup edge and held through the access phase;
   // it stands until the next read setup
   always_comb begin
      prdata_next = prdata_reg;
      if (rdAcc) begin
         case (paddr)
            IFB_OFF_FLAGS0: begin
               prdata_next = readFlags(flags0_reg, IFB_MASK0);
            end
            IFB_OFF_FLAGS1: begin
               prdata_next = readFlags(flags1_reg, IFB_MASK1);
            end
            IFB_OFF_IRQSTAT: begin
               prdata_next = {30'h0, irqStat_reg};
            end
            IFB_OFF_IRQEN: begin
               prdata_next = {30'h0, irqEn_reg};
            end
            // Clear register is write-only and reads as zero, like an unmapped address
            default: begin
               prdata_next = 32'h00000000;
            end
         endcase
      end
   end

   // Read data register
   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata_reg <= 32'h00000000;
      end else if (clkEn) begin
         prdata_reg <= prdata_next;
      end
   end

   // Outputs
   assign prdata              = prdata_reg;
   assign interruptFlagsBank0 = flags0_reg;
   assign interruptFlagsBank1 = flags1_reg;
   assign irq                 = |(irqStat_reg & irqEn_reg);
endmodule : ifb_flag_bank

// [sim/ifb_event_src.sv]
// Peripheral event source model: one-cycle request pulses into the flag bank
`timescale 1ns/1ps
module ifb_event_src (
   // Clock
   input  wire logic        mclk,
   // Request pulses by flag position
   output logic      [15:0] ev0,
   output logic      [15:0] ev1
);
   // Idle with no request
   initial begin
      ev0 = 16'h0;
      ev1 = 16'h0;
   end
   // One request cycle, only where a source exists
   task fire(input logic [15:0] a, input logic [15:0] b);
      @(posedge mclk);
      ev0 <= a & ifb_pkg::IFB_MASK0;
      ev1 <= b & ifb_pkg::IFB_MASK1;
      @(posedge mclk);
      ev0 <= 16'h0;
      ev1 <= 16'h0;
   endtask : fire
endmodule : ifb_event_src

// [sim/ifb_flag_bank_monitor.sv]
// Checker: concurrent properties on the flag bank ports
`timescale 1ns/1ps
module ifb_flag_bank_monitor (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        clkEn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   // Events and flags
   input wire logic        adcDone,
   input wire logic        extPin0,
   input wire logic        serial2Tx,
   input wire logic        i2cSlave1,
   input wire logic [15:0] interruptFlagsBank0,
   input wire logic [15:0] interruptFlagsBank1,
   input wire logic        irq
);
   import ifb_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic wr0;
   // Software write to bank 0 in its access cycle
   assign wr0 = psel && penable && pwrite && (paddr == IFB_OFF_FLAGS0);
   // Properties
   AST_UNIMPL: assert property ((interruptFlagsBank0 & ~IFB_MASK0) == 16'h0 && (interruptFlagsBank1 & ~IFB_MASK1) == 16'h0)
      else $error("unimplemented flag bit set");
   AST_RST: assert property ($past(rst) |-> interruptFlagsBank0 == 16'h0 && interruptFlagsBank1 == 16'h0 && !irq)
      else $error("state not clear after reset");
   AST_ADC: assert property (clkEn && adcDone |=> interruptFlagsBank0[IFB_B0_ADC])
      else $error("conversion flag not latched");
   AST_EXT0: assert property (clkEn && extPin0 |=> interruptFlagsBank0[IFB_B0_EXT0])
      else $error("pin 0 flag not at bit 0");
   AST_S2TX: assert property (clkEn && serial2Tx |=> interruptFlagsBank1[IFB_B1_S2TX])
      else $error("serial 2 transmit flag not latched");
   AST_I2CS: assert property (clkEn && i2cSlave1 |=> interruptFlagsBank1[IFB_B1_I2CS])
      else $error("I2C slave flag not latched");
   AST_HOLD: assert property (!wr0 |=> ($past(interruptFlagsBank0) & ~interruptFlagsBank0) == 16'h0)
      else $error("flag dropped without software write");
   AST_READY: assert property (psel && penable |-> pready)
      else $error("access phase not answered");
   // Main scenarios
   COV_ADC: cover property (adcDone ##1 interruptFlagsBank0[IFB_B0_ADC]);
   COV_WR0: cover property (wr0 && pready);
   COV_IRQ: cover property ($rose(irq));
endmodule : ifb_flag_bank_monitor
bind ifb_flag_bank ifb_flag_bank_monitor ifb_flag_bank_monitor_i (.mclk(mclk), .rst(rst), .clkEn(clkEn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .adcDone(adcDone),
   .extPin0(extPin0), .serial2Tx(serial2Tx), .i2cSlave1(i2cSlave1), .interruptFlagsBank0(interruptFlagsBank0),
   .interruptFlagsBank1(interruptFlagsBank1), .irq(irq));

// [sim/testbench.sv]
// Testbench: register access, event latching and interrupt of the flag bank
`timescale 1ns/1ps
module testbench;
   import ifb_pkg::*;
   logic        mclk, rst, clkEn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [3:0]  pstrb;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] ev0, ev1, flags0, flags1;
   int          miscompares = 0;
   int          tests_run = 0;
   ifb_flag_bank ifb_flag_bank_i (.mclk(mclk), .clkEn(clkEn), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .adcDone(ev0[13]), .serial1Tx(ev0[12]), .serial1Rx(ev0[11]), .spiPort1Event(ev0[10]),
      .spiPort1Fault(ev0[9]), .timer3(ev0[8]), .timer2(ev0[7]), .compare2(ev0[6]), .capture2(ev0[5]),
      .timer1(ev0[3]), .compare1(ev0[2]), .capture1(ev0[1]), .extPin0(ev0[0]), .serial2Tx(ev1[15]),
      .serial2Rx(ev1[14]), .extPin2(ev1[13]), .timer5(ev1[12]), .timer4(ev1[11]), .compare4(ev1[10]),
      .compare3(ev1[9]), .capture8(ev1[7]), .capture7(ev1[6]), .extPin1(ev1[4]), .changeNotify(ev1[3]),
      .comparator(ev1[2]), .i2cMaster1(ev1[1]), .i2cSlave1(ev1[0]), .interruptFlagsBank0(flags0),
      .interruptFlagsBank1(flags1), .irq(irq));
   ifb_event_src ifb_event_src_i (.mclk(mclk), .ev0(ev0), .ev1(ev1));
   // Clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer, started at the next rising edge
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Reset values, then write all ones and zeros to both banks
   task t_rw;
      for (int b = 0; b < 2; b++) begin
         apb(1'b0, b ? IFB_OFF_FLAGS1 : IFB_OFF_FLAGS0, 32'h0);
         chk(rd, 32'h0);
         apb(1'b1, b ? IFB_OFF_FLAGS1 : IFB_OFF_FLAGS0, 32'hffff);
         apb(1'b0, b ? IFB_OFF_FLAGS1 : IFB_OFF_FLAGS0, 32'h0);
         chk(rd, {16'h0, b ? IFB_MASK1 : IFB_MASK0});
         apb(1'b1, b ? IFB_OFF_FLAGS1 : IFB_OFF_FLAGS0, 32'h0);
         apb(1'b0, b ? IFB_OFF_FLAGS1 : IFB_OFF_FLAGS0, 32'h0);
         chk(rd, 32'h0);
      end
   endtask : t_rw
   // Each bit position, fired in both banks at once, lands at that position only
   task t_events;
      logic [15:0] one;
      for (int i = 0; i < 16; i++) begin
         one = 16'h1 << i;
         ifb_event_src_i.fire(one, one);
         apb(1'b0, IFB_OFF_FLAGS0, 32'h0);
         chk(rd, {16'h0, one & IFB_MASK0});
         apb(1'b0, IFB_OFF_FLAGS1, 32'h0);
         chk(rd, {16'h0, one & IFB_MASK1});
         apb(1'b1, IFB_OFF_FLAGS0, 32'h0);
         apb(1'b1, IFB_OFF_FLAGS1, 32'h0);
         @(negedge mclk);
         chk({flags0, flags1}, 32'h0);
      end
   endtask : t_events
   // Event in the very cycle that software writes zero
   task t_race;
      ifb_event_src_i.fire(16'h2000, 16'h0);
      fork
         apb(1'b1, IFB_OFF_FLAGS0, 32'h0);
         begin
            @(posedge mclk);
            ifb_event_src_i.fire(16'h2001, 16'h0);
         end
      join
      apb(1'b0, IFB_OFF_FLAGS0, 32'h0);
      chk(rd, 32'h2001);
   endtask : t_race
   // Interrupt raised, masked, cleared; unmapped access refused
   task t_irq;
      apb(1'b1, IFB_OFF_IRQCLR, 32'h3);
      apb(1'b1, IFB_OFF_IRQEN, 32'h1);
      ifb_event_src_i.fire(16'h0, 16'h0001);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h0);
      ifb_event_src_i.fire(16'h2000, 16'h0);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, IFB_OFF_IRQSTAT, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, IFB_OFF_IRQCLR, 32'h1);
      @(negedge mclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, IFB_OFF_IRQCLR, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
   endtask : t_irq
   // Byte strobes, frozen clock enable and a reset in mid-run
   task t_strobe_reset;
      apb(1'b1, IFB_OFF_FLAGS0, 32'h0);
      pstrb <= 4'h1;
      apb(1'b1, IFB_OFF_FLAGS0, 32'hffff);
      pstrb <= 4'hf;
      apb(1'b0, IFB_OFF_FLAGS0, 32'h0);
      chk(rd, {16'h0, IFB_MASK0 & 16'h00ff});
      clkEn <= 1'b0;
      ifb_event_src_i.fire(16'h2000, 16'h0);
      clkEn <= 1'b1;
      apb(1'b0, IFB_OFF_FLAGS0, 32'h0);
      chk(rd, {16'h0, IFB_MASK0 & 16'h00ff});
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      apb(1'b0, IFB_OFF_FLAGS0, 32'h0);
      chk(rd, 32'h0);
      chk({15'h0, flags1, irq}, 32'h0);
   endtask : t_strobe_reset
   // Verdict
   task print_verdict;
      if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   // Main sequence
   initial begin
      rst = 1'b1;
      clkEn = 1'b1;
      pstrb = 4'hf;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      t_rw();
      t_events();
      t_race();
      t_irq();
      t_strobe_reset();
      print_verdict();
   end
   // Watchdog
   initial begin
      #100us;
      miscompares++;
      print_verdict();
   end
endmodule : testbench
